// File: design/touch_sensor_setup_command_decoder.sv
// design: byte command interpreter of a touch key matrix controller
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_setup_command_decoder
    import touch_cmd_pkg::*;
#(
    parameter longint NULL_TIMEOUT_CYCLES = RESET_NULL_CYCLES
) (
    // system clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // link side: bytes received on the link clock, answers sent on the system clock
    input  wire logic        link_clk,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    output logic             tx_valid,
    output logic [7:0]       tx_byte,
    // sensing core: status lookup for a key index
    output logic [5:0]       status_key,
    output logic [2:0]       status_sel,
    input  wire logic [7:0]  status_value,
    input  wire logic [7:0]  checksum_value,
    input  wire logic [7:0]  device_status,
    input  wire logic [3:0]  key_error,
    input  wire logic [7:0]  first_touch,
    input  wire logic [63:0] touch_map,
    input  wire logic [63:0] error_map,
    input  wire logic        recal_all_done,
    // settings in force and reset request
    output var active_t      active,
    output logic             last_cmd_valid,
    output logic [7:0]       last_cmd,
    output logic             device_reset_req
);
    // ------------------------------------------------------------
    // link domain: capture a byte, pass it by toggle
    // ------------------------------------------------------------
    logic [7:0] link_data_reg;
    logic       link_tgl_reg;
    logic [1:0] link_rst_reg;
    // system reset carried into the link domain through two flops
    always_ff @(posedge link_clk) begin
        link_rst_reg <= {link_rst_reg[0], rst};
    end
    // a byte is held stable until the next one toggles the flag
    always_ff @(posedge link_clk) begin
        if (link_rst_reg[1]) begin
            link_tgl_reg <= 1'b0;
        end else if (rx_valid) begin
            link_data_reg <= rx_byte;
            link_tgl_reg  <= ~link_tgl_reg;
        end
    end

    logic [2:0] tgl_sync_reg;
    logic [7:0] byte_reg;
    logic       byte_stb_reg;
    // two stage synchroniser, the third stage feeds the edge test
    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_sync_reg <= 3'h0;
        end else begin
            tgl_sync_reg <= {tgl_sync_reg[1:0], link_tgl_reg};
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            byte_stb_reg <= 1'b0;
            byte_reg     <= 8'h00;
        end else begin
            byte_stb_reg <= tgl_sync_reg[2] ^ tgl_sync_reg[1];
            if (tgl_sync_reg[2] ^ tgl_sync_reg[1]) begin
                byte_reg <= link_data_reg;   // only taken once the toggle says it is stable
            end
        end
    end

    // ------------------------------------------------------------
    // decoder state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_CMD     = 4'b0001,
        ST_OPERAND = 4'b0010,
        ST_STREAM  = 4'b0100,
        ST_NULL    = 4'b1000
    } state_t;
    state_t      state_reg;
    logic        put_reg;
    scope_t      scope_reg;
    setup_t      setup_reg;
    logic [7:0]  pend_cmd_reg;
    logic [6:0]  stream_left_reg;
    logic [5:0]  stream_key_reg;
    logic [2:0]  stream_sel_reg;
    logic [31:0] null_cnt_reg;

    function automatic logic is_setup(input logic [7:0] c);
        return c == CMD_BC1_HI || c == CMD_BC1_LO || c == CMD_BC2 || c == CMD_NSYNC;
    endfunction
    // single key and group status command ranges
    function automatic logic is_key_stat(input logic [7:0] c);
        return c >= CMD_KEY_FIRST && c <= CMD_KEY_LAST;
    endfunction
    function automatic logic is_grp_stat(input logic [7:0] c);
        return c >= CMD_GRP_FIRST && c <= CMD_GRP_LAST;
    endfunction
    function automatic logic [7:0] setup_value(input setup_t s, input logic [7:0] c);
        unique case (c)
            CMD_BC1_HI: return s.bc1_hi;
            CMD_BC1_LO: return s.bc1_lo;
            CMD_BC2:    return s.bc2;
            default:    return {7'h00, s.nsync};
        endcase
    endfunction
    // first key of a scope and its member count
    function automatic logic [5:0] scope_first(input scope_t s);
        unique case (s.kind)
            SCOPE_ROW: return {s.index[2:0], 3'h0};
            SCOPE_COL: return {3'h0, s.index[2:0]};
            SCOPE_KEY: return s.index;
            default:   return 6'h00;
        endcase
    endfunction
    function automatic logic [6:0] scope_size(input scope_t s);
        unique case (s.kind)
            SCOPE_KEY: return 7'd1;
            SCOPE_ALL: return 7'(GROUP_ALL);
            default:   return 7'(GROUP_LINE);
        endcase
    endfunction
    function automatic logic [5:0] scope_step(input scope_t s, input logic [5:0] k);
        return (s.kind == SCOPE_COL) ? 6'(k + 6'd8) : 6'(k + 6'd1);
    endfunction

    // ------------------------------------------------------------
    // main command sequencer
    // ------------------------------------------------------------
    logic       in_byte;
    logic [7:0] b;
    assign in_byte = byte_stb_reg;
    assign b       = byte_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg       <= ST_CMD;
            put_reg         <= 1'b0;
            scope_reg       <= '{kind: SCOPE_ALL, index: 6'h00};
            setup_reg       <= '{bc1_hi: BC1_HI_DEF, bc1_lo: BC1_LO_DEF, bc2: BC2_DEF, nsync: 1'b0};
            pend_cmd_reg    <= 8'h00;
            stream_left_reg <= 7'h00;
            stream_key_reg  <= 6'h00;
            stream_sel_reg  <= 3'h0;
            null_cnt_reg    <= 32'h0;
            tx_valid        <= 1'b0;
            tx_byte         <= 8'h00;
            last_cmd_valid  <= 1'b0;
            last_cmd        <= 8'h00;
            device_reset_req <= 1'b0;
        end else begin
            tx_valid         <= 1'b0;
            last_cmd_valid   <= 1'b0;
            device_reset_req <= 1'b0;
            unique case (state_reg)
                ST_CMD: if (in_byte) begin
                    last_cmd       <= b;
                    last_cmd_valid <= 1'b1;
                    pend_cmd_reg   <= b;
                    if (b == CMD_GET || b == CMD_PUT) begin
                        put_reg  <= (b == CMD_PUT);
                        tx_valid <= 1'b1;
                        tx_byte  <= b;
                    end else if (b == CMD_SCOPE_ALL) begin
                        scope_reg.kind <= SCOPE_ALL;
                        tx_valid <= 1'b1;
                        tx_byte  <= b;
                    end else if (b == CMD_SCOPE_KEY || b == CMD_SCOPE_ROW || b == CMD_SCOPE_COL
                                 || (is_setup(b) && put_reg)) begin
                        state_reg <= ST_OPERAND;
                    end else if (is_setup(b)) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= setup_value(setup_reg, b);
                    end else if (b == CMD_RESET && put_reg) begin
                        null_cnt_reg <= 32'h0;
                        state_reg    <= ST_NULL;
                    end else if (is_key_stat(b)) begin
                        stream_key_reg  <= scope_first(scope_reg);
                        stream_sel_reg  <= 3'(b - CMD_KEY_FIRST);
                        stream_left_reg <= 7'd1;
                        state_reg       <= ST_STREAM;
                    end else if (is_grp_stat(b)) begin
                        stream_key_reg  <= scope_first(scope_reg);
                        stream_sel_reg  <= 3'(b - CMD_GRP_FIRST);
                        stream_left_reg <= scope_size(scope_reg);
                        state_reg       <= ST_STREAM;
                    end else if (b == CMD_CHECKSUM) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= checksum_value;
                    end else if (b == CMD_STATUS) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= (device_status > STATUS_MAX) ? STATUS_MAX : device_status;
                    end else if (b == CMD_ERR_KEY) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= {4'h0, key_error};
                    end else if (b == CMD_ERR_GRP) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= error_map[scope_first(scope_reg) +: 8];
                    end else if (b == CMD_TOUCH_1ST) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= first_touch;
                    end else if (b == CMD_TOUCH_GRP) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= touch_map[scope_first(scope_reg) +: 8];
                    end
                end
                ST_OPERAND: if (in_byte) begin
                    state_reg <= ST_CMD;
                    tx_valid  <= 1'b1;
                    tx_byte   <= pend_cmd_reg;        // echo
                    unique case (pend_cmd_reg)
                        CMD_SCOPE_KEY: if (b <= 8'(KEY_MAX)) begin
                            scope_reg <= '{kind: SCOPE_KEY, index: b[5:0]};
                        end
                        CMD_SCOPE_ROW: if (b <= LINE_MAX) begin
                            scope_reg <= '{kind: SCOPE_ROW, index: b[5:0]};
                        end
                        CMD_SCOPE_COL: if (b <= LINE_MAX) begin
                            scope_reg <= '{kind: SCOPE_COL, index: b[5:0]};
                        end
                        CMD_BC1_HI: if (put_reg && b <= BC1_HI_MAX) begin
                            setup_reg.bc1_hi <= b;
                        end
                        CMD_BC1_LO: if (put_reg) begin
                            setup_reg.bc1_lo <= b;
                        end
                        CMD_BC2: if (put_reg) begin
                            setup_reg.bc2 <= b;
                        end
                        CMD_NSYNC: if (put_reg && b <= NSYNC_MAX) begin
                            setup_reg.nsync <= b[0];
                        end
                        default: ;
                    endcase
                end
                ST_STREAM: begin
                    if (stream_left_reg == 7'd0) begin
                        state_reg <= ST_CMD;
                    end else begin
                        tx_valid        <= 1'b1;
                        tx_byte         <= (stream_sel_reg == 3'h4 && status_value > CHARGE_MAX)
                                           ? CHARGE_MAX : status_value;
                        stream_key_reg  <= scope_step(scope_reg, stream_key_reg);
                        stream_left_reg <= 7'(stream_left_reg - 7'd1);
                    end
                end
                ST_NULL: begin
                    null_cnt_reg <= 32'(null_cnt_reg + 32'd1);
                    if (in_byte) begin
                        state_reg <= ST_CMD;
                        if (b == NULL_BYTE) begin
                            tx_valid         <= 1'b1;
                            tx_byte          <= CMD_RESET;
                            device_reset_req <= 1'b1;
                        end
                    end else if (longint'(null_cnt_reg) >= NULL_TIMEOUT_CYCLES - 1) begin
                        state_reg <= ST_CMD;          // request dropped
                    end
                end
                default: state_reg <= ST_CMD;
            endcase
        end
    end

    // status lookup address steps with the stream walk and holds the same key as stream_key_reg each clock, so the
    // core answer for a key stands when that key's byte is registered
    always_ff @(posedge clk) begin
        if (rst) begin
            status_key <= 6'h00;
            status_sel <= 3'h0;
        end else if (state_reg == ST_CMD && in_byte && is_key_stat(b)) begin
            status_key <= scope_first(scope_reg);
            status_sel <= 3'(b - CMD_KEY_FIRST);
        end else if (state_reg == ST_CMD && in_byte && is_grp_stat(b)) begin
            status_key <= scope_first(scope_reg);
            status_sel <= 3'(b - CMD_GRP_FIRST);
        end else if (state_reg == ST_STREAM) begin
            status_key <= scope_step(scope_reg, stream_key_reg);
        end
    end

    // ------------------------------------------------------------
    // settings in force: loaded at reset or on reset command; boundary constants also on recal
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            active.boundary_constant_one <= 16'(BC1_HI_WEIGHT * BC1_HI_DEF) + 16'(BC1_LO_DEF);
            active.boundary_constant_two <= BC2_DEF;
            active.noise_sync_on         <= 1'b0;
        end else begin
            if (device_reset_req || recal_all_done) begin
                active.boundary_constant_one <= 16'(BC1_HI_WEIGHT * int'(setup_reg.bc1_hi))
                                                + 16'(setup_reg.bc1_lo);
                active.boundary_constant_two <= setup_reg.bc2;
            end
            if (device_reset_req) begin
                active.noise_sync_on <= setup_reg.nsync;
            end
        end
    end
endmodule
`default_nettype wire

// File: shared/touch_cmd_pkg.sv
// package: command codes, defaults, types and timing for the touch setup command decoder
package touch_cmd_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_BC1_HI    = 8'h14;
    localparam logic [7:0] CMD_BC1_LO    = 8'h15;
    localparam logic [7:0] CMD_BC2       = 8'h16;
    localparam logic [7:0] CMD_NSYNC     = 8'h17;
    localparam logic [7:0] CMD_GET       = 8'h67;
    localparam logic [7:0] CMD_PUT       = 8'h70;
    localparam logic [7:0] CMD_SCOPE_KEY = 8'h73;
    localparam logic [7:0] CMD_SCOPE_ALL = 8'h53;
    localparam logic [7:0] CMD_SCOPE_ROW = 8'h78;
    localparam logic [7:0] CMD_SCOPE_COL = 8'h79;
    localparam logic [7:0] CMD_KEY_FIRST = 8'h30;
    localparam logic [7:0] CMD_KEY_LAST  = 8'h35;
    localparam logic [7:0] CMD_GRP_FIRST = 8'h20;
    localparam logic [7:0] CMD_GRP_LAST  = 8'h25;
    localparam logic [7:0] CMD_CHECKSUM  = 8'h36;
    localparam logic [7:0] CMD_STATUS    = 8'h37;
    localparam logic [7:0] CMD_ERR_KEY   = 8'h65;
    localparam logic [7:0] CMD_ERR_GRP   = 8'h45;
    localparam logic [7:0] CMD_TOUCH_1ST = 8'h6B;
    localparam logic [7:0] CMD_TOUCH_GRP = 8'h4B;
    localparam logic [7:0] CMD_RESET     = 8'h72;
    localparam logic [7:0] NULL_BYTE     = 8'h00;
    // ------------------------------------------------------------
    // ranges and defaults
    // ------------------------------------------------------------
    localparam logic [7:0] BC1_HI_MAX    = 8'h7F;
    localparam logic [5:0] KEY_MAX       = 6'h3F;
    localparam logic [7:0] LINE_MAX      = 8'h07;
    localparam logic [7:0] NSYNC_MAX     = 8'h01;
    localparam logic [7:0] STATUS_MAX    = 8'h1F;
    localparam logic [7:0] ERR_KEY_MASK  = 8'h0F;
    localparam logic [7:0] CHARGE_MAX    = 8'h02;
    localparam logic [7:0] BC1_HI_DEF    = 8'h05;
    localparam logic [7:0] BC1_LO_DEF    = 8'hE9;
    localparam logic [7:0] BC2_DEF       = 8'h08;
    localparam int         GROUP_LINE    = 8;
    localparam int         GROUP_ALL     = 64;
    localparam int         BC1_HI_WEIGHT = 256;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         CLK_HZ        = 200_000_000;
    localparam int         RESET_NULL_MS = 100;
    localparam longint     RESET_NULL_CYCLES = longint'(CLK_HZ) / 1000 * RESET_NULL_MS;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SCOPE_KEY = 2'h0,
        SCOPE_ROW = 2'h1,
        SCOPE_COL = 2'h2,
        SCOPE_ALL = 2'h3
    } scope_kind_t;
    typedef struct packed {
        scope_kind_t kind;
        logic [5:0]  index;
    } scope_t;
    typedef struct packed {
        logic [7:0] bc1_hi;
        logic [7:0] bc1_lo;
        logic [7:0] bc2;
        logic       nsync;
    } setup_t;
    typedef struct packed {
        logic [15:0] boundary_constant_one;
        logic [7:0]  boundary_constant_two;
        logic        noise_sync_on;
    } active_t;
endpackage

// File: verification/link_host_model.sv
// partner: host side link master handing bytes to the decoder
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
    // link clock
    input  wire logic  link_clk,
    // received byte strobe and data
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    // idle: no strobe
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // one byte, strobed for one link cycle; caller keeps the spacing and order
    task automatic send(input logic [7:0] b);
        @(posedge link_clk);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge link_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b;  // released line shows no stale byte
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// testbench: random and corner case byte commands against the setup command decoder
`timescale 1ns/1ps
`default_nettype none
`define check(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench
    import touch_cmd_pkg::*;
;
    localparam int LIMIT = 20000;
    logic        clk = 1'b0, link_clk = 1'b0, rst = 1'b1, recal_all_done = 1'b0;
    logic        rx_valid, tx_valid, last_cmd_valid, device_reset_req;
    logic [7:0]  rx_byte, tx_byte, status_value, last_cmd, hi, lo, c2, k, rnd = 8'h1C;
    logic [7:0]  checksum_value = 8'h00, device_status = 8'h00, first_touch = 8'h00;
    logic [5:0]  status_key;
    logic [2:0]  status_sel;
    logic [3:0]  key_error = 4'h0;
    logic [63:0] touch_map = '0, error_map = '0;
    active_t     active;
    logic [7:0]  rxq[$];
    int          num_errors = 0, tests_run = 0, cycles = 0, resets_seen = 0;
    // clocks: system 5 ns, link 48 ns with its own phase
    always #2.5 clk = ~clk;
    initial begin
        #7.3;
        forever #24 link_clk = ~link_clk;
    end
    // random source and sensing core model
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] stat(input logic [5:0] kk, input logic [2:0] s);
        return {kk, 2'b01} ^ {s, 5'h0B};
    endfunction
    function automatic logic [7:0] stat_exp(input logic [5:0] kk, input logic [2:0] s);
        return (s == 3'h4 && stat(kk, s) > CHARGE_MAX) ? CHARGE_MAX : stat(kk, s);  // charge state capped
    endfunction
    assign status_value = stat(status_key, status_sel);
    link_host_model link_host_model_i (.link_clk(link_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
    touch_sensor_setup_command_decoder #(.NULL_TIMEOUT_CYCLES(200)) touch_sensor_setup_command_decoder_i (
        .clk(clk), .rst(rst), .link_clk(link_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .status_key(status_key), .status_sel(status_sel),
        .status_value(status_value), .checksum_value(checksum_value), .device_status(device_status),
        .key_error(key_error), .first_touch(first_touch), .touch_map(touch_map), .error_map(error_map),
        .recal_all_done(recal_all_done), .active(active), .last_cmd_valid(last_cmd_valid),
        .last_cmd(last_cmd), .device_reset_req(device_reset_req));
    // collect answers, count reset requests, cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (tx_valid === 1'b1)
            rxq.push_back(tx_byte);
        if (device_reset_req === 1'b1)
            resets_seen++;
        if (cycles == LIMIT) begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // send one byte, wait past any answer stream, check the answer count
    task automatic cmd(input logic [7:0] b, input int n);
        rxq.delete();
        link_host_model_i.send(b);
        repeat (n > 1 ? 150 : 30) @(posedge clk);
        `check("answer count", n, rxq.size())
    endtask
    task automatic ask(input logic [7:0] b, input logic [7:0] e);
        cmd(b, 1);
        `check("answer byte", e, rxq[0])
    endtask
    task automatic put(input logic [7:0] b, input logic [7:0] v);
        cmd(b, 0);
        ask(v, b);
    endtask
    task automatic grp(input logic [7:0] b, input int first, input int step, input int n);
        cmd(b, n);
        for (int i = 0; i < n; i++)
            `check("group byte", stat_exp(6'(first + i * step), 3'(b - CMD_GRP_FIRST)), rxq[i])
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rnd = lfsr(rnd);
        checksum_value <= rnd;
        device_status <= rnd ^ 8'hA5 | 8'h20;  // above the cap on purpose
        key_error <= rnd[3:0];
        first_touch <= ~rnd;
        touch_map <= {8{rnd}} ^ 64'h0123456789ABCDEF;
        error_map <= {8{rnd}} ^ 64'hFEDCBA9876543210;
        repeat (10) @(posedge clk);
        ask(CMD_BC1_HI, BC1_HI_DEF);
        ask(CMD_BC1_LO, BC1_LO_DEF);
        ask(CMD_BC2, BC2_DEF);
        ask(CMD_NSYNC, 8'h00);
        cmd(8'h01, 0);
        ask(CMD_NSYNC, 8'h00);
        ask(CMD_PUT, CMD_PUT);
        rnd = lfsr(rnd);
        hi = rnd & BC1_HI_MAX;
        rnd = lfsr(rnd);
        lo = rnd;
        rnd = lfsr(rnd);
        c2 = rnd;
        put(CMD_BC1_HI, hi);
        put(CMD_BC1_LO, lo);
        put(CMD_BC2, c2);
        put(CMD_NSYNC, 8'h01);
        put(CMD_BC1_HI, 8'h80);
        put(CMD_NSYNC, 8'h02);
        `check("last command", CMD_NSYNC, last_cmd)
        `check("settings in force", {BC1_HI_DEF, BC1_LO_DEF, BC2_DEF, 1'b0}, active)
        ask(CMD_GET, CMD_GET);
        ask(CMD_BC1_HI, hi);
        ask(CMD_BC1_LO, lo);
        ask(CMD_BC2, c2);
        ask(CMD_NSYNC, 8'h01);
        @(posedge clk) recal_all_done <= 1'b1;
        @(posedge clk) recal_all_done <= 1'b0;
        repeat (4) @(posedge clk);
        `check("settings after recal", {hi, lo, c2, 1'b0}, active)
        ask(CMD_PUT, CMD_PUT);
        cmd(CMD_RESET, 0);
        repeat (250) @(posedge clk);
        cmd(NULL_BYTE, 0);
        `check("reset requests", 0, resets_seen)
        cmd(CMD_RESET, 0);
        ask(NULL_BYTE, CMD_RESET);
        `check("reset requests", 1, resets_seen)
        `check("noise sync in force", 1'b1, active.noise_sync_on)
        ask(CMD_GET, CMD_GET);
        rnd = lfsr(rnd);
        k = rnd & 8'h3F;
        cmd(CMD_SCOPE_KEY, 0);
        ask(k, CMD_SCOPE_KEY);
        for (int s = 0; s < 6; s++)
            ask(CMD_KEY_FIRST + 8'(s), stat_exp(k[5:0], 3'(s)));
        cmd(CMD_SCOPE_ROW, 0);
        ask(k & 8'h07, CMD_SCOPE_ROW);
        for (int s = 0; s < 6; s++)
            grp(CMD_GRP_FIRST + 8'(s), (k & 8'h07) * 8, 1, 8);
        cmd(CMD_SCOPE_COL, 0);
        ask(k >> 3, CMD_SCOPE_COL);
        grp(8'h23, k >> 3, 8, 8);
        ask(CMD_SCOPE_ALL, CMD_SCOPE_ALL);
        cmd(CMD_SCOPE_ROW, 0);
        ask(8'h08, CMD_SCOPE_ROW);
        grp(CMD_GRP_LAST, 0, 1, 64);
        ask(CMD_CHECKSUM, checksum_value);
        ask(CMD_STATUS, STATUS_MAX);
        ask(CMD_ERR_KEY, {4'h0, key_error});
        ask(CMD_ERR_GRP, error_map[7:0]);
        ask(CMD_TOUCH_1ST, first_touch);
        ask(CMD_TOUCH_GRP, touch_map[7:0]);
        close_out();
    end
endmodule
`default_nettype wire

// File: verification/touch_cmd_checker_asserts.sv
// checker: timing relations on the ports of the setup command decoder
`timescale 1ns/1ps
`default_nettype none
module touch_cmd_checker
    import touch_cmd_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // answers and command record
    input wire logic       tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic       last_cmd_valid,
    input wire logic [7:0] last_cmd,
    // core levels and settings in force
    input wire logic [3:0] key_error,
    input wire logic       recal_all_done,
    input wire active_t    active,
    input wire logic       device_reset_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // settings in force only move on a reset command or a full recalibration
    a_reset_defaults: assert property ($fell(rst) |-> !tx_valid && active == {BC1_HI_DEF, BC1_LO_DEF, BC2_DEF, 1'b0})
        else $error("defaults not in force after reset");
    a_upper_range: assert property (active.boundary_constant_one[15] == 1'b0)
        else $error("upper boundary byte above its range");
    a_settings_hold: assert property ($changed(active) |-> $past(device_reset_req) || $past(recal_all_done)
        || $past(recal_all_done, 2))
        else $error("settings changed without reset or recalibration");
    a_sync_on_reset: assert property ($changed(active.noise_sync_on) |-> $past(device_reset_req))
        else $error("noise sync changed without reset command");
    a_reset_echo: assert property (device_reset_req |-> tx_valid && tx_byte == CMD_RESET ##1 !device_reset_req)
        else $error("reset request without single echo");
    // answers tied to the command that caused them
    a_dir_echo: assert property (last_cmd_valid && (last_cmd == CMD_GET || last_cmd == CMD_PUT
        || last_cmd == CMD_SCOPE_ALL) |-> ##[0:2] tx_valid && tx_byte == last_cmd)
        else $error("direction or scope command not echoed");
    a_status_cap: assert property (last_cmd_valid && last_cmd == CMD_STATUS
        |-> ##[0:2] tx_valid && tx_byte <= STATUS_MAX)
        else $error("device status answer above cap");
    a_key_error: assert property (last_cmd_valid && last_cmd == CMD_ERR_KEY
        |-> ##[0:2] tx_valid && tx_byte == {4'h0, key_error})
        else $error("key error answer wrong");
endmodule
bind touch_sensor_setup_command_decoder touch_cmd_checker touch_cmd_checker_i (
    .clk(clk), .rst(rst), .tx_valid(tx_valid), .tx_byte(tx_byte), .last_cmd_valid(last_cmd_valid),
    .last_cmd(last_cmd), .key_error(key_error), .recal_all_done(recal_all_done), .active(active),
    .device_reset_req(device_reset_req));
`default_nettype wire
